// [hdl/asr_baud_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module asr_baud_timer #(
    parameter int DIV_W = 16
) (
    input wire logic i_ref_clk, // System clock
    input wire logic i_nrst, // Asynchronous reset, active low
    input wire logic i_clear, // Restart the timer
    input wire logic [DIV_W-1:0] i_divisor, // Divisor pair value
    input wire logic i_wide, // Full divisor width in use
    input wire logic i_fast, // High speed select
    output logic o_tick // Oversampling tick, one cycle
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [1:0] pre;
        logic tick;
    } asr_baud_state_type;

    asr_baud_state_type s_ff;
    asr_baud_state_type nxt_s;
    logic [DIV_W-1:0] limit;

    // Narrow mode uses only the low divisor byte
    assign limit = i_wide ? i_divisor
        : {{(DIV_W-asr_pkg::BYTE_W){1'b0}}, i_divisor[asr_pkg::BYTE_W-1:0]};

    // Prescaler by four in slow narrow mode, then the divisor counter
    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        nxt_s.pre = s_ff.pre + 1'b1;
        if (i_clear) begin
            nxt_s = '0;
        end else if (i_fast || i_wide || s_ff.pre == asr_pkg::PRE_LAST) begin
            if (s_ff.cnt == limit) begin
                nxt_s.cnt = '0;
                nxt_s.tick = 1'b1;
            end else begin
                nxt_s.cnt = s_ff.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_tick = s_ff.tick;
endmodule : asr_baud_timer
`default_nettype wire

// [hdl/asr_receiver.sv]
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module asr_receiver (
    input wire logic i_ref_clk, // System clock, 10 MHz
    input wire logic i_nrst, // Asynchronous reset, active low
    input wire logic i_rx_pin, // Serial receive line
    input wire asr_pkg::asr_axil_req_type i_axi, // Bus requests
    output var asr_pkg::asr_axil_rsp_type o_axi, // Bus responses
    output logic o_rx_pending, // Unread character waiting
    output logic o_rx_irq // Receive interrupt request
);
    asr_pkg::asr_rx_reg_type r_ff;
    asr_pkg::asr_rx_reg_type nxt_r;
    asr_pkg::asr_entry_type head;
    logic tick;
    logic active;
    logic fall;
    logic maj;
    logic decide;
    logic w_take;
    logic r_take;
    logic pop;
    logic push;
    logic keep;
    logic full;
    logic store;
    logic brg_wr;
    logic wr_idx;
    logic framing_err_flag_vis;
    logic [3:0] nbits;
    logic [8:0] rx_word;
    logic [31:0] rd_word;

    // Word address match
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction : hit

    // Address belongs to a register
    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, asr_pkg::OFF_CTRL) || hit(addr, asr_pkg::OFF_DATA)
            || hit(addr, asr_pkg::OFF_BRG_LO) || hit(addr, asr_pkg::OFF_BRG_HI)
            || hit(addr, asr_pkg::OFF_BAUD_CFG) || hit(addr, asr_pkg::OFF_IRQ);
    endfunction : mapped

    // Two of three samples high
    function automatic logic majority(input logic [1:0] votes, input logic last);
        majority = votes[1] || (votes[0] && last);
    endfunction : majority

    // Reception gating and line events
    assign active = r_ff.port_en && r_ff.rx_en && !r_ff.sync_mode;
    assign fall = r_ff.line_prev && !r_ff.line;
    assign maj = majority(r_ff.votes, r_ff.line);
    assign decide = tick && (r_ff.sub == asr_pkg::SUB_DECIDE);
    assign nbits = r_ff.nine ? asr_pkg::BITS_NINE : asr_pkg::BITS_EIGHT;

    // Bus handshakes
    assign w_take = i_axi.awvalid && i_axi.wvalid && !r_ff.bvalid;
    assign r_take = i_axi.arvalid && !r_ff.rvalid;
    assign pop = r_take && hit(i_axi.araddr, asr_pkg::OFF_DATA) && (r_ff.cnt != '0);
    assign brg_wr = w_take && i_axi.wstrb[0]
        && (hit(i_axi.awaddr, asr_pkg::OFF_BRG_LO) || hit(i_axi.awaddr, asr_pkg::OFF_BRG_HI));

    // Character completion and store decisions
    assign push = (r_ff.st == asr_pkg::ST_STOP) && decide && active;
    assign rx_word = r_ff.nine ? r_ff.shreg : {1'b0, r_ff.shreg[8:1]};
    assign keep = !(r_ff.addr_detect_enable && r_ff.nine && !r_ff.shreg[8]);
    assign full = (r_ff.cnt == asr_pkg::FIFO_DEPTH) && !pop;
    assign store = push && keep && !full;
    assign wr_idx = r_ff.rd_ptr ^ r_ff.cnt[0];
    assign head = r_ff.fifo[r_ff.rd_ptr];
    assign framing_err_flag_vis = (r_ff.cnt != '0) && head.framing_err_flag;

    // Baud timer restarts on divisor writes and while the port is off
    asr_baud_timer #(
        .DIV_W(asr_pkg::DIV_W)
    ) u_baud (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_clear(brg_wr || !r_ff.port_en),
        .i_divisor({r_ff.brg_hi, r_ff.brg_lo}),
        .i_wide(r_ff.wide),
        .i_fast(r_ff.fast),
        .o_tick(tick)
    );

    // Read data selection
    always_comb begin
        rd_word = '0;
        if (hit(i_axi.araddr, asr_pkg::OFF_CTRL)) begin
            rd_word[asr_pkg::CTRL_PORT_EN] = r_ff.port_en;
            rd_word[asr_pkg::CTRL_RX_EN] = r_ff.rx_en;
            rd_word[asr_pkg::CTRL_SYNC] = r_ff.sync_mode;
            rd_word[asr_pkg::CTRL_NINE] = r_ff.nine;
            rd_word[asr_pkg::CTRL_ADDR_DETECT_ENABLE] = r_ff.addr_detect_enable;
            rd_word[asr_pkg::STAT_FRAMING_ERR_FLAG] = framing_err_flag_vis;
            rd_word[asr_pkg::STAT_OVERRUN_ERR_FLAG] = r_ff.overrun_err_flag;
            rd_word[asr_pkg::STAT_NINTH] = (r_ff.cnt != '0) && head.data[8];
            rd_word[asr_pkg::STAT_IDLE] = (r_ff.st == asr_pkg::ST_IDLE);
        end else if (hit(i_axi.araddr, asr_pkg::OFF_DATA)) begin
            rd_word[asr_pkg::BYTE_W-1:0] = head.data[asr_pkg::BYTE_W-1:0];
        end else if (hit(i_axi.araddr, asr_pkg::OFF_BRG_LO)) begin
            rd_word[asr_pkg::BYTE_W-1:0] = r_ff.brg_lo;
        end else if (hit(i_axi.araddr, asr_pkg::OFF_BRG_HI)) begin
            rd_word[asr_pkg::BYTE_W-1:0] = r_ff.brg_hi;
        end else if (hit(i_axi.araddr, asr_pkg::OFF_BAUD_CFG)) begin
            rd_word[asr_pkg::CFG_FAST] = r_ff.fast;
            rd_word[asr_pkg::CFG_WIDE] = r_ff.wide;
        end else if (hit(i_axi.araddr, asr_pkg::OFF_IRQ)) begin
            rd_word[asr_pkg::IRQ_RX_EN] = r_ff.rie;
            rd_word[asr_pkg::IRQ_PERIPH_EN] = r_ff.pie;
            rd_word[asr_pkg::IRQ_GLOBAL_EN] = r_ff.global_irq_enable;
            rd_word[asr_pkg::IRQ_PENDING] = o_rx_pending;
        end
    end

    // Next state of the whole block
    always_comb begin
        nxt_r = r_ff;
        // Three stage synchroniser, change taken when last two agree
        nxt_r.sync = {r_ff.sync[1:0], i_rx_pin};
        if (r_ff.sync[1] == r_ff.sync[2]) begin
            nxt_r.line = r_ff.sync[2];
        end
        nxt_r.line_prev = r_ff.line;

        // Tick counter within a bit and vote collection
        if (tick && r_ff.st != asr_pkg::ST_IDLE) begin
            nxt_r.sub = r_ff.sub + 1'b1;
            if (r_ff.sub == asr_pkg::SUB_VOTE0) begin
                nxt_r.votes = {1'b0, r_ff.line};
            end else if (r_ff.sub == asr_pkg::SUB_VOTE1) begin
                nxt_r.votes = r_ff.votes + {1'b0, r_ff.line};
            end
        end

        // Bit sequencing
        unique case (r_ff.st)
            asr_pkg::ST_IDLE: begin
                if (active && !r_ff.overrun_err_flag && fall) begin
                    nxt_r.st = asr_pkg::ST_START;
                    nxt_r.sub = '0;
                end
            end
            asr_pkg::ST_START: begin
                if (decide && maj) begin
                    nxt_r.st = asr_pkg::ST_IDLE;
                end else if (tick && r_ff.sub == asr_pkg::SUB_LAST) begin
                    nxt_r.st = asr_pkg::ST_DATA;
                    nxt_r.bitn = '0;
                    nxt_r.shreg = '0;
                end
            end
            asr_pkg::ST_DATA: begin
                if (decide) begin
                    nxt_r.shreg = {maj, r_ff.shreg[8:1]};
                    nxt_r.bitn = r_ff.bitn + 1'b1;
                end else if (tick && r_ff.sub == asr_pkg::SUB_LAST && r_ff.bitn == nbits) begin
                    nxt_r.st = asr_pkg::ST_STOP;
                end
            end
            asr_pkg::ST_STOP: begin
                if (decide) begin
                    nxt_r.st = asr_pkg::ST_IDLE;
                end
            end
        endcase
        if (!active) begin
            nxt_r.st = asr_pkg::ST_IDLE;
        end

        // Receiver disable acts from the registered enable so a same-cycle overrun set wins
        if (!r_ff.rx_en) begin
            nxt_r.overrun_err_flag = 1'b0;
        end

        // Store, overrun and removal
        if (push && keep && full) begin
            nxt_r.overrun_err_flag = 1'b1;
        end
        if (store) begin
            nxt_r.fifo[wr_idx].framing_err_flag = !maj;
            nxt_r.fifo[wr_idx].data = rx_word;
        end
        if (store && !pop) begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
        end else if (pop && !store) begin
            nxt_r.cnt = r_ff.cnt - 1'b1;
        end
        if (pop) begin
            nxt_r.rd_ptr = !r_ff.rd_ptr;
        end
        // Port disable wins over a data read in the same cycle
        if (!r_ff.port_en) begin
            nxt_r.cnt = '0;
            nxt_r.rd_ptr = 1'b0;
            nxt_r.overrun_err_flag = 1'b0;
        end

        // Write channel
        if (r_ff.bvalid && i_axi.bready) begin
            nxt_r.bvalid = 1'b0;
        end
        if (w_take) begin
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = mapped(i_axi.awaddr) ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
            if (i_axi.wstrb[0]) begin
                if (hit(i_axi.awaddr, asr_pkg::OFF_CTRL)) begin
                    nxt_r.port_en = i_axi.wdata[asr_pkg::CTRL_PORT_EN];
                    nxt_r.rx_en = i_axi.wdata[asr_pkg::CTRL_RX_EN];
                    nxt_r.sync_mode = i_axi.wdata[asr_pkg::CTRL_SYNC];
                    nxt_r.nine = i_axi.wdata[asr_pkg::CTRL_NINE];
                    nxt_r.addr_detect_enable = i_axi.wdata[asr_pkg::CTRL_ADDR_DETECT_ENABLE];
                end
                if (hit(i_axi.awaddr, asr_pkg::OFF_BRG_LO)) begin
                    nxt_r.brg_lo = i_axi.wdata[asr_pkg::BYTE_W-1:0];
                end
                if (hit(i_axi.awaddr, asr_pkg::OFF_BRG_HI)) begin
                    nxt_r.brg_hi = i_axi.wdata[asr_pkg::BYTE_W-1:0];
                end
                if (hit(i_axi.awaddr, asr_pkg::OFF_BAUD_CFG)) begin
                    nxt_r.fast = i_axi.wdata[asr_pkg::CFG_FAST];
                    nxt_r.wide = i_axi.wdata[asr_pkg::CFG_WIDE];
                end
                if (hit(i_axi.awaddr, asr_pkg::OFF_IRQ)) begin
                    nxt_r.rie = i_axi.wdata[asr_pkg::IRQ_RX_EN];
                    nxt_r.pie = i_axi.wdata[asr_pkg::IRQ_PERIPH_EN];
                    nxt_r.global_irq_enable = i_axi.wdata[asr_pkg::IRQ_GLOBAL_EN];
                end
            end
        end

        // Read channel
        if (r_ff.rvalid && i_axi.rready) begin
            nxt_r.rvalid = 1'b0;
        end
        if (r_take) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rdata = rd_word;
            nxt_r.rresp = mapped(i_axi.araddr) ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Flags and bus outputs
    assign o_rx_pending = r_ff.port_en && r_ff.rx_en && (r_ff.cnt != '0);
    assign o_rx_irq = o_rx_pending && r_ff.rie && r_ff.pie && r_ff.global_irq_enable;
    assign o_axi.awready = w_take;
    assign o_axi.wready = w_take;
    assign o_axi.bvalid = r_ff.bvalid;
    assign o_axi.bresp = r_ff.bresp;
    assign o_axi.arready = !r_ff.rvalid;
    assign o_axi.rvalid = r_ff.rvalid;
    assign o_axi.rdata = r_ff.rdata;
    assign o_axi.rresp = r_ff.rresp;

    // Checks on the receive path
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    property p_gate;
        r_ff.st == asr_pkg::ST_IDLE && !active |=> r_ff.st == asr_pkg::ST_IDLE;
    endproperty
    a_gate: assert property (p_gate) else $error("Reception started while inactive");

    property p_abort;
        r_ff.st == asr_pkg::ST_START && decide && maj
            |=> r_ff.st == asr_pkg::ST_IDLE && !r_ff.overrun_err_flag ##1 !$rose(r_ff.overrun_err_flag);
    endproperty
    a_abort: assert property (p_abort) else $error("False start not abandoned");

    property p_shift;
        r_ff.st == asr_pkg::ST_DATA && decide
            |=> r_ff.bitn == $past(r_ff.bitn) + 1'b1 && r_ff.shreg[8] == $past(maj);
    endproperty
    a_shift: assert property (p_shift) else $error("Bit not shifted at centre");

    property p_flag;
        store |=> o_rx_pending && r_ff.cnt != '0;
    endproperty
    a_flag: assert property (p_flag) else $error("Pending not raised after store");

    property p_framing_err_flag;
        store && r_ff.cnt == '0 |=> framing_err_flag_vis == $past(!maj);
    endproperty
    a_framing_err_flag: assert property (p_framing_err_flag) else $error("Framing flag wrong for character");

    property p_pop;
        pop && !store |=> r_ff.cnt == $past(r_ff.cnt) - 1'b1;
    endproperty
    a_pop: assert property (p_pop) else $error("Data read did not remove entry");

    property p_overrun;
        push && keep && full |=> r_ff.overrun_err_flag && r_ff.cnt == asr_pkg::FIFO_DEPTH;
    endproperty
    a_overrun: assert property (p_overrun) else $error("Overrun not flagged");

    property p_overrun_err_flag_hold;
        r_ff.overrun_err_flag && r_ff.rx_en && r_ff.port_en |=> r_ff.overrun_err_flag;
    endproperty
    a_overrun_err_flag_hold: assert property (p_overrun_err_flag_hold) else $error("Overrun cleared early");

    property p_port_off;
        !r_ff.port_en |=> r_ff.cnt == '0 && !framing_err_flag_vis && !r_ff.overrun_err_flag;
    endproperty
    a_port_off: assert property (p_port_off) else $error("Port disable left state");

    property p_irq;
        o_rx_irq |-> o_rx_pending && r_ff.rie && r_ff.pie && r_ff.global_irq_enable;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt without all enables");

    property p_addr;
        push && r_ff.addr_detect_enable && r_ff.nine && !r_ff.shreg[8] |=> $stable(r_ff.fifo);
    endproperty
    a_addr: assert property (p_addr) else $error("Data character stored in address mode");

    property p_pend_sw;
        r_ff.cnt == '0 && !store |=> !o_rx_pending;
    endproperty
    a_pend_sw: assert property (p_pend_sw) else $error("Pending set without a character");

    property p_overrun_err_flag_block;
        r_ff.overrun_err_flag && r_ff.st == asr_pkg::ST_IDLE |=> r_ff.st == asr_pkg::ST_IDLE;
    endproperty
    a_overrun_err_flag_block: assert property (p_overrun_err_flag_block) else $error("Reception resumed in overrun");

    c_overrun: cover property ($rose(r_ff.overrun_err_flag));
    c_framing: cover property (store && !maj);
    c_abort: cover property (r_ff.st == asr_pkg::ST_START && decide && maj);
    c_nine: cover property (store && r_ff.nine && r_ff.shreg[8]);
endmodule : asr_receiver
`default_nettype wire

// [pkg/asr_pkg.sv]
// Operation
// - Sample the line at sixteen ticks per bit; shift once per bit.
// - Hold two whole characters in a small first-in-first-out store.
// - Receive only with receiver enabled, port enabled and synchronous mode off.
// - A falling edge on the idle line starts a character.
// - Line high at mid start bit abandons the character silently.
// - Each later bit is decided by majority vote at its centre.
// - A low stop bit marks a framing error for that character.
// - A complete character enters the store and raises the pending flag.
// - Pending is high while enabled with an unread character; software cannot change it.
// - Interrupt request needs pending plus receive, peripheral and global enables.
// - Reading the data register returns and removes the oldest character.
// - Each entry keeps its own framing bit; the oldest shows, read only.
// - Framing errors neither block reception nor raise an interrupt.
// - Port disable resets reception, the store and overrun and clears framing; receiver disable keeps it.
// - Framing flag stays set while every stored character has framing errors.
// - A third complete character with two stored sets overrun and blocks reception.
// - Overrun clears only by disabling the receiver or the port.
// - Nine-bit mode shifts nine bits and shows the oldest ninth bit.
// - In nine-bit mode, address detection keeps only characters whose ninth bit is one.
// - Data bits arrive least significant bit first.
// - Writing either divisor byte restarts the baud timer at once.
package asr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_BRG_LO = 8'h08;
    localparam logic [7:0] OFF_BRG_HI = 8'h0c;
    localparam logic [7:0] OFF_BAUD_CFG = 8'h10;
    localparam logic [7:0] OFF_IRQ = 8'h14;
    // Control and status bit positions
    localparam int CTRL_PORT_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_SYNC = 2;
    localparam int CTRL_NINE = 3;
    localparam int CTRL_ADDR_DETECT_ENABLE = 4;
    localparam int STAT_FRAMING_ERR_FLAG = 8;
    localparam int STAT_OVERRUN_ERR_FLAG = 9;
    localparam int STAT_NINTH = 10;
    localparam int STAT_IDLE = 11;
    localparam int CFG_FAST = 0;
    localparam int CFG_WIDE = 1;
    localparam int IRQ_RX_EN = 0;
    localparam int IRQ_PERIPH_EN = 1;
    localparam int IRQ_GLOBAL_EN = 2;
    localparam int IRQ_PENDING = 8;
    // Widths and counts
    localparam int BYTE_W = 8;
    localparam int DIV_W = 16;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [1:0] PRE_LAST = 2'h3;
    // Oversampling points within one bit of sixteen ticks
    localparam logic [3:0] SUB_VOTE0 = 4'h7;
    localparam logic [3:0] SUB_VOTE1 = 4'h8;
    localparam logic [3:0] SUB_DECIDE = 4'h9;
    localparam logic [3:0] SUB_LAST = 4'hf;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} asr_rx_state_type;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } asr_axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } asr_axil_rsp_type;

    typedef struct packed {
        logic framing_err_flag;
        logic [8:0] data;
    } asr_entry_type;

    typedef struct packed {
        logic [2:0] sync;
        logic line;
        logic line_prev;
        asr_rx_state_type st;
        logic [3:0] sub;
        logic [3:0] bitn;
        logic [1:0] votes;
        logic [8:0] shreg;
        asr_entry_type [1:0] fifo;
        logic rd_ptr;
        logic [1:0] cnt;
        logic overrun_err_flag;
        logic port_en;
        logic rx_en;
        logic sync_mode;
        logic nine;
        logic addr_detect_enable;
        logic rie;
        logic pie;
        logic global_irq_enable;
        logic fast;
        logic wide;
        logic [7:0] brg_lo;
        logic [7:0] brg_hi;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } asr_rx_reg_type;
endpackage : asr_pkg

// [test/asr_tx_model.sv]
`timescale 1ns/1ns
`default_nettype none
module asr_tx_model (
    input wire logic i_ref_clk, // System clock
    output logic o_line // Serial line, idle high
);
    int bit_clks = 16;
    // Line idles at mark
    initial o_line = 1'b1;
    // Start, data bits and stop, each bit_clks clocks long
    task send(input logic [8:0] d, input int nb, input logic stop);
        o_line <= 1'b0;
        repeat (bit_clks) @(posedge i_ref_clk);
        for (int i = 0; i < nb; i++) begin
            o_line <= d[i];
            repeat (bit_clks) @(posedge i_ref_clk);
        end
        o_line <= stop;
        repeat (bit_clks) @(posedge i_ref_clk);
        o_line <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
    endtask : send
    // Low pulse shorter than half a bit
    task glitch(input int n);
        o_line <= 1'b0;
        repeat (n) @(posedge i_ref_clk);
        o_line <= 1'b1;
        repeat (24) @(posedge i_ref_clk);
    endtask : glitch
endmodule : asr_tx_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk;
    logic nrst;
    logic line;
    asr_pkg::asr_axil_req_type req;
    asr_pkg::asr_axil_rsp_type rsp;
    logic pend;
    logic irq;
    logic [31:0] rdat;
    logic [1:0] rrsp;
    logic [1:0] brsp;
    int n_fail = 0;
    int compares = 0;

    asr_receiver asr_receiver_inst (
        .i_ref_clk(clk),
        .i_nrst(nrst),
        .i_rx_pin(line),
        .i_axi(req),
        .o_axi(rsp),
        .o_rx_pending(pend),
        .o_rx_irq(irq)
    );
    asr_tx_model asr_tx_model_inst (.i_ref_clk(clk), .o_line(line));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Compare a word
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Compare a flag
    task chkb(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask : chkb
    // Bus write, ready and response awaited at rising edges
    task wr(input logic [7:0] a, input logic [31:0] d);
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        do @(posedge clk); while (!(rsp.awready && rsp.wready));
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(posedge clk); while (!rsp.bvalid);
        brsp = rsp.bresp;
    endtask : wr
    // Bus read
    task rd(input logic [7:0] a);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do @(posedge clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (!rsp.rvalid);
        rdat = rsp.rdata;
        rrsp = rsp.rresp;
    endtask : rd
    // Status word without the idle bit
    task stat(input logic [31:0] e);
        rd(asr_pkg::OFF_CTRL);
        chk("status", e, rdat & 32'h7ff);
    endtask : stat
    task rdd(input logic [31:0] e);
        rd(asr_pkg::OFF_DATA);
        chk("data", e, rdat);
    endtask : rdd
    task stop_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        stop_test;
    end
    // Test sequence
    initial begin
        nrst = 1'b0;
        req = '0;
        req.wstrb = 4'hf;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(asr_pkg::OFF_CTRL);
        chk("status", 32'h800, rdat);
        rd(8'h18);
        chk("rresp", 32'(asr_pkg::RESP_SLVERR), 32'(rrsp));
        wr(8'h18, 32'h1);
        chk("bresp", 32'(asr_pkg::RESP_SLVERR), 32'(brsp));
        wr(asr_pkg::OFF_IRQ, 32'h100);
        rd(asr_pkg::OFF_IRQ);
        chk("irq_reg", 32'h0, rdat);
        $display("test reset done");
        // Sync mode blocks, glitch aborts, good character
        wr(asr_pkg::OFF_BAUD_CFG, 32'h1);
        wr(asr_pkg::OFF_CTRL, 32'h7);
        asr_tx_model_inst.send(9'h0a5, 8, 1'b1);
        chkb("pend", 1'b0, pend);
        wr(asr_pkg::OFF_CTRL, 32'h3);
        asr_tx_model_inst.glitch(4);
        chkb("pend", 1'b0, pend);
        asr_tx_model_inst.send(9'h0a5, 8, 1'b1);
        chkb("pend", 1'b1, pend);
        wr(asr_pkg::OFF_IRQ, 32'h3);
        chkb("irq", 1'b0, irq);
        wr(asr_pkg::OFF_IRQ, 32'h7);
        chkb("irq", 1'b1, irq);
        rd(asr_pkg::OFF_IRQ);
        chk("irq_reg", 32'h107, rdat);
        rdd(32'ha5);
        chkb("pend", 1'b0, pend);
        chkb("irq", 1'b0, irq);
        $display("test basic done");
        // Framing errors, overrun and its clearing
        asr_tx_model_inst.send(9'h011, 8, 1'b0);
        asr_tx_model_inst.send(9'h022, 8, 1'b0);
        asr_tx_model_inst.send(9'h033, 8, 1'b1);
        stat(32'h303);
        rdd(32'h11);
        stat(32'h303);
        asr_tx_model_inst.send(9'h044, 8, 1'b1);
        wr(asr_pkg::OFF_CTRL, 32'h1);
        stat(32'h101);
        chkb("pend", 1'b0, pend);
        wr(asr_pkg::OFF_CTRL, 32'h3);
        chkb("pend", 1'b1, pend);
        rdd(32'h22);
        chkb("pend", 1'b0, pend);
        asr_tx_model_inst.send(9'h055, 8, 1'b0);
        wr(asr_pkg::OFF_CTRL, 32'h0);
        wr(asr_pkg::OFF_CTRL, 32'h3);
        stat(32'h003);
        chkb("pend", 1'b0, pend);
        $display("test errors done");
        // Nine-bit reception with address detection
        wr(asr_pkg::OFF_CTRL, 32'h1b);
        asr_tx_model_inst.send(9'h0aa, 9, 1'b1);
        chkb("pend", 1'b0, pend);
        asr_tx_model_inst.send(9'h155, 9, 1'b1);
        chkb("pend", 1'b1, pend);
        stat(32'h41b);
        rdd(32'h55);
        wr(asr_pkg::OFF_CTRL, 32'h0b);
        asr_tx_model_inst.send(9'h0c3, 9, 1'b1);
        stat(32'h00b);
        rdd(32'hc3);
        $display("test ninebit done");
        // Slower rate after a divisor write: two clocks a tick
        wr(asr_pkg::OFF_CTRL, 32'h3);
        wr(asr_pkg::OFF_BRG_LO, 32'h1);
        asr_tx_model_inst.bit_clks = 32;
        asr_tx_model_inst.send(9'h096, 8, 1'b1);
        stat(32'h003);
        rdd(32'h96);
        rd(asr_pkg::OFF_BRG_LO);
        chk("brg_lo", 32'h1, rdat);
        // Slow prescaler: four clocks a tick
        wr(asr_pkg::OFF_BAUD_CFG, 32'h0);
        wr(asr_pkg::OFF_BRG_LO, 32'h0);
        asr_tx_model_inst.bit_clks = 64;
        asr_tx_model_inst.send(9'h069, 8, 1'b1);
        rdd(32'h69);
        // Full width divisor bypasses the prescaler: two clocks a tick
        wr(asr_pkg::OFF_BAUD_CFG, 32'h2);
        wr(asr_pkg::OFF_BRG_LO, 32'h1);
        asr_tx_model_inst.bit_clks = 32;
        asr_tx_model_inst.send(9'h05a, 8, 1'b1);
        rdd(32'h5a);
        $display("test divisor done");
        stop_test;
    end
endmodule : testbench
`default_nettype wire
